// >>> src/ccfg_loader.sv
// option loader: latches the programmed option word during reset and applies it
// assumes a static option word, an avalon-mm master and pins synchronous to i_mclk
//
// What this block does
// - read protection on: program read-back is refused, zero returned.
// - read protection off: program words read back unchanged.
// - option field picks one of eight brown-out levels for the reset comparator.
// - boot option slow or fast selects wake-up and start-up delay lengths.
// - irq bit 0 comes from port a bit 0 or port b bit 5.
// - irq bit 1 comes from port b bit 0 or port a bit 4.
// - gating on: comparator controls all pwm outputs; off: no control.
// - led pwm clock bit set: fast oscillator, 16 or doubled 32 mhz.
// - timer two select 0010: fast oscillator, 16 or doubled 32 mhz.
// - timer two scale bit 7 set: pwm resolution 6 or 7 bits.
// - comparator irq on both, rising or falling edges per option.
module ccfg_loader #(
  parameter int WUP_SLOW_CYC = ccfg_pkg::WUP_SLOW_CYC,  // slow wake-up cycles
  parameter int WUP_FAST_CYC = ccfg_pkg::WUP_FAST_CYC,  // fast wake-up cycles
  parameter int SBP_SLOW_CYC = ccfg_pkg::SBP_SLOW_CYC,  // slow start-up cycles
  parameter int SBP_FAST_CYC = ccfg_pkg::SBP_FAST_CYC   // fast start-up cycles
) (
  input  wire logic        i_mclk,              // system clock, 50 mhz
  input  wire logic        i_rst_b,             // sync reset, active low
  input  wire logic [12:0] i_opt_word,          // programmed option word
  // avalon-mm slave
  input  wire logic [3:0]  i_avs_address,       // byte address
  input  wire logic        i_avs_read,          // read request
  input  wire logic        i_avs_write,         // write request
  input  wire logic [31:0] i_avs_writedata,     // write data
  input  wire logic [3:0]  i_avs_byteenable,    // byte enables
  output logic      [31:0] o_avs_readdata,      // read data
  output logic             o_avs_waitrequest,   // stall
  // program read-back
  input  wire logic        i_prog_rd_req,       // read-back request
  input  wire logic [15:0] i_prog_rd_data,      // stored program word
  output logic      [15:0] o_prog_rd_data,      // returned word
  output logic             o_prog_rd_valid,     // returned word valid
  output logic             o_prog_rd_refused,   // read-back refused
  // static configuration
  output logic      [2:0]  o_brownout_reset_level, // brown-out level code
  output logic             o_boot_fast,            // fast boot selected
  output logic      [19:0] o_wakeup_cycles,        // wake-up delay length
  output logic      [19:0] o_startup_cycles,       // start-up delay length
  // interrupt sources
  input  wire logic        i_pa0,               // port a bit 0
  input  wire logic        i_pb5,               // port b bit 5
  input  wire logic        i_pb0,               // port b bit 0
  input  wire logic        i_pa4,               // port a bit 4
  output logic      [1:0]  o_irq_src,           // feeds irq_request_flags bits 1:0
  // comparator and pwm
  input  wire logic        i_cmp_out,           // comparator output
  input  wire logic [7:0]  i_pwm,               // raw pwm outputs
  output logic      [7:0]  o_pwm,               // pwm after gating
  output logic             o_cmp_irq,           // comparator irq pulse
  // clock selection
  output logic             o_led_pwm_fosc_en,   // led pwm runs from fast osc
  output logic             o_led_pwm_fosc_dbl,  // fast osc doubled to 32 mhz
  output logic             o_tm2_fosc_en,       // timer two runs from fast osc
  output logic             o_tm2_fosc_dbl,      // fast osc doubled to 32 mhz
  output logic             o_tm2_pwm_en,        // timer two pwm mode
  output logic      [3:0]  o_tm2_pwm_bits       // timer two pwm resolution
);

  ////////////////////////////////////////////////////////////////////////////
  // option latch

  logic [12:0] opt_r;
  logic [12:0] opt_nxt;

  // follow the option word only while reset is held
  always_comb begin
    opt_nxt = opt_r;
    if (!i_rst_b) begin
      opt_nxt = i_opt_word;
    end
  end

  always_ff @(posedge i_mclk) begin
    opt_r <= opt_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon-mm register file

  logic        wait_r;
  logic        wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [7:0]  led_clk_r;
  logic [7:0]  led_clk_nxt;
  logic [7:0]  tm2_ctrl_r;
  logic [7:0]  tm2_ctrl_nxt;
  logic [7:0]  tm2_scale_r;
  logic [7:0]  tm2_scale_nxt;
  logic        req;
  logic        wr_go;

  assign req   = i_avs_read | i_avs_write;
  assign wr_go = i_avs_write & ~wait_r & i_avs_byteenable[0];

  // one stall cycle, then the answer; the option register ignores writes
  always_comb begin
    wait_nxt      = ~(req & wait_r);
    rdata_nxt     = rdata_r;
    led_clk_nxt   = led_clk_r;
    tm2_ctrl_nxt  = tm2_ctrl_r;
    tm2_scale_nxt = tm2_scale_r;
    if (i_avs_read && wait_r) begin
      unique case (i_avs_address)
        ccfg_pkg::REG_OPT_STAT:  rdata_nxt = {19'h0, opt_r};
        ccfg_pkg::REG_LED_CLK:   rdata_nxt = {24'h0, led_clk_r};
        ccfg_pkg::REG_TM2_CTRL:  rdata_nxt = {24'h0, tm2_ctrl_r};
        ccfg_pkg::REG_TM2_SCALE: rdata_nxt = {24'h0, tm2_scale_r};
        default:                 rdata_nxt = 32'h0;
      endcase
    end
    if (wr_go) begin
      unique case (i_avs_address)
        ccfg_pkg::REG_LED_CLK:   led_clk_nxt   = i_avs_writedata[7:0];
        ccfg_pkg::REG_TM2_CTRL:  tm2_ctrl_nxt  = i_avs_writedata[7:0];
        ccfg_pkg::REG_TM2_SCALE: tm2_scale_nxt = i_avs_writedata[7:0];
        default:                 led_clk_nxt   = led_clk_r;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      wait_r      <= 1'b1;
      rdata_r     <= 32'h0;
      led_clk_r   <= ccfg_pkg::LED_CLK_RST;
      tm2_ctrl_r  <= ccfg_pkg::TM2_CTRL_RST;
      tm2_scale_r <= ccfg_pkg::TM2_SCALE_RST;
    end else begin
      wait_r      <= wait_nxt;
      rdata_r     <= rdata_nxt;
      led_clk_r   <= led_clk_nxt;
      tm2_ctrl_r  <= tm2_ctrl_nxt;
      tm2_scale_r <= tm2_scale_nxt;
    end
  end

  assign o_avs_waitrequest = wait_r;
  assign o_avs_readdata    = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // routing helper

  ccfg_route_if rt ();

  // option fields onto the carrier
  always_comb begin
    rt.src0_pb5 = opt_r[ccfg_pkg::OPT_SRC0];
    rt.src1_pa4 = opt_r[ccfg_pkg::OPT_SRC1];
    rt.gate_en  = opt_r[ccfg_pkg::OPT_GATE];
    rt.edge_sel = opt_r[ccfg_pkg::OPT_EDGE_LO +: 2];
  end

  ccfg_route u_route (
    .i_mclk    (i_mclk),
    .i_rst_b   (i_rst_b),
    .i_pa0     (i_pa0),
    .i_pb5     (i_pb5),
    .i_pb0     (i_pb0),
    .i_pa4     (i_pa4),
    .i_cmp_out (i_cmp_out),
    .i_pwm     (i_pwm),
    .rt        (rt.router)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registered configuration outputs

  logic        rd_valid_r;
  logic        rd_valid_nxt;
  logic        rd_refused_r;
  logic        rd_refused_nxt;
  logic [15:0] rd_data_r;
  logic [15:0] rd_data_nxt;
  logic [2:0]  bor_r;
  logic [2:0]  bor_nxt;
  logic        boot_fast_r;
  logic        boot_fast_nxt;
  logic [19:0] wup_r;
  logic [19:0] wup_nxt;
  logic [19:0] sbp_r;
  logic [19:0] sbp_nxt;
  logic [1:0]  irq_src_r;
  logic [1:0]  irq_src_nxt;
  logic [7:0]  pwm_r;
  logic [7:0]  pwm_nxt;
  logic        cmp_irq_r;
  logic        cmp_irq_nxt;
  logic        led_en_r;
  logic        led_en_nxt;
  logic        led_dbl_r;
  logic        led_dbl_nxt;
  logic        tm2_en_r;
  logic        tm2_en_nxt;
  logic        tm2_dbl_r;
  logic        tm2_dbl_nxt;
  logic        tm2_pwm_r;
  logic        tm2_pwm_nxt;
  logic [3:0]  tm2_bits_r;
  logic [3:0]  tm2_bits_nxt;

  // decode options and control registers into the outputs
  always_comb begin
    rd_valid_nxt   = i_prog_rd_req & ~opt_r[ccfg_pkg::OPT_SECURE];
    rd_refused_nxt = i_prog_rd_req & opt_r[ccfg_pkg::OPT_SECURE];
    rd_data_nxt    = opt_r[ccfg_pkg::OPT_SECURE] ? 16'h0 : i_prog_rd_data;
    bor_nxt        = opt_r[ccfg_pkg::OPT_BOR_LO +: 3];
    boot_fast_nxt  = opt_r[ccfg_pkg::OPT_BOOT_FAST];
    wup_nxt        = boot_fast_nxt ? 20'(WUP_FAST_CYC) : 20'(WUP_SLOW_CYC);
    sbp_nxt        = boot_fast_nxt ? 20'(SBP_FAST_CYC) : 20'(SBP_SLOW_CYC);
    irq_src_nxt    = rt.irq_src;
    pwm_nxt        = rt.pwm_gated;
    cmp_irq_nxt    = rt.cmp_irq;
    led_en_nxt     = led_clk_r[ccfg_pkg::LED_CLK_EN_BIT];
    led_dbl_nxt    = led_en_nxt & opt_r[ccfg_pkg::OPT_PWM_DBL];
    tm2_en_nxt     = tm2_ctrl_r[ccfg_pkg::TM2_SEL_LO +: 4] == ccfg_pkg::TM2_SEL_FOSC;
    tm2_dbl_nxt    = tm2_en_nxt & opt_r[ccfg_pkg::OPT_TM2_DBL];
    tm2_pwm_nxt    = tm2_scale_r[ccfg_pkg::TM2_PWM_EN_BIT];
    tm2_bits_nxt   = opt_r[ccfg_pkg::OPT_TM2_7BIT] ? ccfg_pkg::PWM_BITS_7
                                                   : ccfg_pkg::PWM_BITS_6;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      rd_valid_r   <= 1'b0;
      rd_refused_r <= 1'b0;
      rd_data_r    <= 16'h0;
      bor_r        <= 3'h0;
      boot_fast_r  <= 1'b0;
      wup_r        <= 20'h0;
      sbp_r        <= 20'h0;
      irq_src_r    <= 2'h0;
      pwm_r        <= 8'h0;
      cmp_irq_r    <= 1'b0;
      led_en_r     <= 1'b0;
      led_dbl_r    <= 1'b0;
      tm2_en_r     <= 1'b0;
      tm2_dbl_r    <= 1'b0;
      tm2_pwm_r    <= 1'b0;
      tm2_bits_r   <= ccfg_pkg::PWM_BITS_6;
    end else begin
      rd_valid_r   <= rd_valid_nxt;
      rd_refused_r <= rd_refused_nxt;
      rd_data_r    <= rd_data_nxt;
      bor_r        <= bor_nxt;
      boot_fast_r  <= boot_fast_nxt;
      wup_r        <= wup_nxt;
      sbp_r        <= sbp_nxt;
      irq_src_r    <= irq_src_nxt;
      pwm_r        <= pwm_nxt;
      cmp_irq_r    <= cmp_irq_nxt;
      led_en_r     <= led_en_nxt;
      led_dbl_r    <= led_dbl_nxt;
      tm2_en_r     <= tm2_en_nxt;
      tm2_dbl_r    <= tm2_dbl_nxt;
      tm2_pwm_r    <= tm2_pwm_nxt;
      tm2_bits_r   <= tm2_bits_nxt;
    end
  end

  // outputs straight from flops
  assign o_prog_rd_valid        = rd_valid_r;
  assign o_prog_rd_refused      = rd_refused_r;
  assign o_prog_rd_data         = rd_data_r;
  assign o_brownout_reset_level = bor_r;
  assign o_boot_fast            = boot_fast_r;
  assign o_wakeup_cycles        = wup_r;
  assign o_startup_cycles       = sbp_r;
  assign o_irq_src              = irq_src_r;
  assign o_pwm                  = pwm_r;
  assign o_cmp_irq              = cmp_irq_r;
  assign o_led_pwm_fosc_en      = led_en_r;
  assign o_led_pwm_fosc_dbl     = led_dbl_r;
  assign o_tm2_fosc_en          = tm2_en_r;
  assign o_tm2_fosc_dbl         = tm2_dbl_r;
  assign o_tm2_pwm_en           = tm2_pwm_r;
  assign o_tm2_pwm_bits         = tm2_bits_r;
endmodule

// >>> src/ccfg_pkg.sv
// constants shared by the option loader and its routing helper
// assumes a 50 MHz system clock and a 13-bit programmed option word
package ccfg_pkg;
  localparam int          CLK_MHZ        = 50;
  localparam int          OPT_W          = 13;
  // option word field positions
  localparam int          OPT_SECURE     = 0;
  localparam int          OPT_BOR_LO     = 1;
  localparam int          OPT_BOOT_FAST  = 4;
  localparam int          OPT_SRC0       = 5;
  localparam int          OPT_SRC1       = 6;
  localparam int          OPT_GATE       = 7;
  localparam int          OPT_PWM_DBL    = 8;
  localparam int          OPT_TM2_DBL    = 9;
  localparam int          OPT_TM2_7BIT   = 10;
  localparam int          OPT_EDGE_LO    = 11;
  // register byte offsets
  localparam logic [3:0]  REG_OPT_STAT   = 4'h0;
  localparam logic [3:0]  REG_LED_CLK    = 4'h4;
  localparam logic [3:0]  REG_TM2_CTRL   = 4'h8;
  localparam logic [3:0]  REG_TM2_SCALE  = 4'hc;
  // register reset values
  localparam logic [7:0]  LED_CLK_RST    = 8'h00;
  localparam logic [7:0]  TM2_CTRL_RST   = 8'h00;
  localparam logic [7:0]  TM2_SCALE_RST  = 8'h00;
  // decode constants
  localparam logic [3:0]  TM2_SEL_FOSC   = 4'h2;
  localparam int          TM2_SEL_LO     = 4;
  localparam int          TM2_PWM_EN_BIT = 7;
  localparam int          LED_CLK_EN_BIT = 0;
  localparam logic [3:0]  PWM_BITS_6     = 4'h6;
  localparam logic [3:0]  PWM_BITS_7     = 4'h7;
  // boot delays in microseconds and their cycle counts
  localparam int          WUP_SLOW_US    = 1000;
  localparam int          WUP_FAST_US    = 50;
  localparam int          SBP_SLOW_US    = 2000;
  localparam int          SBP_FAST_US    = 100;
  localparam int          WUP_SLOW_CYC   = WUP_SLOW_US * CLK_MHZ;
  localparam int          WUP_FAST_CYC   = WUP_FAST_US * CLK_MHZ;
  localparam int          SBP_SLOW_CYC   = SBP_SLOW_US * CLK_MHZ;
  localparam int          SBP_FAST_CYC   = SBP_FAST_US * CLK_MHZ;

  typedef enum logic [1:0] {
    CCFG_EDGE_ALL,
    CCFG_EDGE_RISE,
    CCFG_EDGE_FALL,
    CCFG_EDGE_RSVD
  } ccfg_edge_t;
endpackage

// >>> src/ccfg_route_if.sv
// carrier between the option loader and its routing helper
// assumes both ends share the system clock
interface ccfg_route_if;
  logic       src0_pb5;   // bit-0 irq from second pin
  logic       src1_pa4;   // bit-1 irq from second pin
  logic       gate_en;    // comparator gates pwm
  logic [1:0] edge_sel;   // comparator irq edge kind
  logic [1:0] irq_src;    // routed irq source levels
  logic [7:0] pwm_gated;  // pwm after gating
  logic       cmp_irq;    // comparator edge event

  modport loader (output src0_pb5, output src1_pa4, output gate_en, output edge_sel,
                  input irq_src, input pwm_gated, input cmp_irq);
  modport router (input src0_pb5, input src1_pa4, input gate_en, input edge_sel,
                  output irq_src, output pwm_gated, output cmp_irq);
endinterface

// >>> src/ccfg_route.sv
// irq source muxing, comparator gating of pwm and comparator edge detection
// assumes pin levels synchronous to i_mclk; results are registered by the loader
module ccfg_route (
  input  wire logic       i_mclk,     // system clock
  input  wire logic       i_rst_b,    // sync reset, active low
  input  wire logic       i_pa0,      // port a bit 0
  input  wire logic       i_pb5,      // port b bit 5
  input  wire logic       i_pb0,      // port b bit 0
  input  wire logic       i_pa4,      // port a bit 4
  input  wire logic       i_cmp_out,  // comparator output
  input  wire logic [7:0] i_pwm,      // raw pwm outputs
  ccfg_route_if.router    rt          // option side
);
  logic cmp_prev_r;
  logic cmp_prev_nxt;

  // remember last comparator level for edge detection
  always_comb begin
    cmp_prev_nxt = i_cmp_out;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      cmp_prev_r <= 1'b0;
    end else begin
      cmp_prev_r <= cmp_prev_nxt;
    end
  end

  // routing and edge selection
  always_comb begin
    rt.irq_src[0] = rt.src0_pb5 ? i_pb5 : i_pa0;
    rt.irq_src[1] = rt.src1_pa4 ? i_pa4 : i_pb0;
    rt.pwm_gated  = rt.gate_en ? (i_pwm & {8{i_cmp_out}}) : i_pwm;
    unique case (ccfg_pkg::ccfg_edge_t'(rt.edge_sel))
      ccfg_pkg::CCFG_EDGE_RISE: rt.cmp_irq = i_cmp_out & ~cmp_prev_r;
      ccfg_pkg::CCFG_EDGE_FALL: rt.cmp_irq = ~i_cmp_out & cmp_prev_r;
      default:                  rt.cmp_irq = i_cmp_out ^ cmp_prev_r;
    endcase
  end
endmodule

// >>> verif/ccfg_loader_chk.sv
// checker for the option loader: watches only the top-level ports
// assumes the bind below and the loader's one-edge output lag
module ccfg_loader_chk #(
  parameter int WUP_SLOW_CYC = 10, // slow wake-up cycles
  parameter int WUP_FAST_CYC = 5,  // fast wake-up cycles
  parameter int SBP_SLOW_CYC = 20, // slow start-up cycles
  parameter int SBP_FAST_CYC = 8   // fast start-up cycles
) (
  input wire logic        i_mclk,                 // system clock
  input wire logic        i_rst_b,                // sync reset, active low
  input wire logic [12:0] i_opt_word,             // option word
  input wire logic        i_avs_read,             // bus read
  input wire logic        i_avs_write,            // bus write
  input wire logic        o_avs_waitrequest,      // bus stall
  input wire logic        i_prog_rd_req,          // read-back request
  input wire logic [15:0] i_prog_rd_data,         // stored word
  input wire logic [15:0] o_prog_rd_data,         // returned word
  input wire logic        o_prog_rd_valid,        // returned word valid
  input wire logic        o_prog_rd_refused,      // read-back refused
  input wire logic [2:0]  o_brownout_reset_level, // brown-out code
  input wire logic [19:0] o_wakeup_cycles,        // wake-up length
  input wire logic [19:0] o_startup_cycles,       // start-up length
  input wire logic        i_pa0,                  // pin
  input wire logic        i_pb5,                  // pin
  input wire logic        i_pb0,                  // pin
  input wire logic        i_pa4,                  // pin
  input wire logic [1:0]  o_irq_src,              // routed irq levels
  input wire logic        i_cmp_out,              // comparator
  input wire logic [7:0]  i_pwm,                  // raw pwm
  input wire logic [7:0]  o_pwm,                  // gated pwm
  input wire logic        o_led_pwm_fosc_en,      // led pwm fast osc
  input wire logic        o_led_pwm_fosc_dbl,     // led pwm doubled
  input wire logic        o_tm2_fosc_en,          // timer two fast osc
  input wire logic        o_tm2_fosc_dbl,         // timer two doubled
  input wire logic [3:0]  o_tm2_pwm_bits          // timer two resolution
);
  logic [12:0] opt_r;
  logic [12:0] opt_nxt;
  logic        run;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  ////////////////////////////////////////////////////////////////////////////////
  // own copy of the option word, captured only while reset is low
  always_comb opt_nxt = i_rst_b ? opt_r : i_opt_word;
  always_ff @(posedge i_mclk) opt_r <= opt_nxt;
  assign run = i_rst_b;

  ////////////////////////////////////////////////////////////////////////////////
  // properties
  a_prog_refuse: assert property ($past(run) && $past(i_prog_rd_req) && opt_r[0] |->
    o_prog_rd_refused && !o_prog_rd_valid && o_prog_rd_data == 16'h0000)
    else $error("read-back not refused");
  a_prog_pass: assert property ($past(run) && $past(i_prog_rd_req) && !opt_r[0] |->
    o_prog_rd_valid && o_prog_rd_data == $past(i_prog_rd_data))
    else $error("read-back word wrong");
  a_bor_level: assert property ($past(run) |-> o_brownout_reset_level == opt_r[3:1])
    else $error("brown-out code wrong");
  a_boot_len: assert property ($past(run) |->
    o_wakeup_cycles == 20'(opt_r[4] ? WUP_FAST_CYC : WUP_SLOW_CYC) &&
    o_startup_cycles == 20'(opt_r[4] ? SBP_FAST_CYC : SBP_SLOW_CYC))
    else $error("boot delay length wrong");
  a_irq0_route: assert property ($past(run) |->
    o_irq_src[0] == (opt_r[5] ? $past(i_pb5) : $past(i_pa0))) else $error("irq bit 0 wrong");
  a_irq1_route: assert property ($past(run) |->
    o_irq_src[1] == (opt_r[6] ? $past(i_pa4) : $past(i_pb0))) else $error("irq bit 1 wrong");
  a_pwm_gate: assert property ($past(run) |-> o_pwm == (opt_r[7] ?
    ($past(i_pwm) & {8{$past(i_cmp_out)}}) : $past(i_pwm))) else $error("pwm gating wrong");
  a_led_double: assert property ($past(run) |->
    o_led_pwm_fosc_dbl == (o_led_pwm_fosc_en & opt_r[8])) else $error("led clock double wrong");
  a_tm2_double: assert property ($past(run) |->
    o_tm2_fosc_dbl == (o_tm2_fosc_en & opt_r[9])) else $error("timer clock double wrong");
  a_tm2_bits: assert property ($past(run) |->
    o_tm2_pwm_bits == (opt_r[10] ? 4'h7 : 4'h6)) else $error("timer resolution wrong");
  a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=>
    !o_avs_waitrequest) else $error("bus answer late");
endmodule

bind ccfg_loader ccfg_loader_chk #(.WUP_SLOW_CYC(WUP_SLOW_CYC), .WUP_FAST_CYC(WUP_FAST_CYC),
  .SBP_SLOW_CYC(SBP_SLOW_CYC), .SBP_FAST_CYC(SBP_FAST_CYC)) chk_u (.*);

// >>> verif/tb_top.sv
// self-checking bench for the option loader, one scenario per option word
// assumes the loader with shortened boot counts and its bound checker
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WS = 10, WF = 5, SS = 20, SF = 8;
  logic        i_mclk = 1'h0, i_rst_b = 1'h0, i_avs_read = 1'h0, i_avs_write = 1'h0;
  logic        i_prog_rd_req = 1'h0, i_cmp_out = 1'h0;
  logic        i_pa0 = 1'h0, i_pb5 = 1'h0, i_pb0 = 1'h0, i_pa4 = 1'h0;
  logic [12:0] i_opt_word = 13'h0000;
  logic [3:0]  i_avs_address = 4'h0, i_avs_byteenable = 4'hf, o_tm2_pwm_bits;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata;
  logic [15:0] i_prog_rd_data = 16'h0000, o_prog_rd_data;
  logic [7:0]  i_pwm = 8'h00, o_pwm;
  logic [2:0]  o_brownout_reset_level;
  logic [19:0] o_wakeup_cycles, o_startup_cycles;
  logic [1:0]  o_irq_src;
  logic        o_avs_waitrequest, o_prog_rd_valid, o_prog_rd_refused, o_boot_fast, o_cmp_irq;
  logic        o_led_pwm_fosc_en, o_led_pwm_fosc_dbl, o_tm2_fosc_en, o_tm2_fosc_dbl, o_tm2_pwm_en;
  int          mismatches = 0, checks = 0, cyc = 0;

  ccfg_loader #(.WUP_SLOW_CYC(WS), .WUP_FAST_CYC(WF), .SBP_SLOW_CYC(SS),
    .SBP_FAST_CYC(SF)) dut_u (.*);

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial forever #10 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_read <= !wr;
    i_avs_write <= wr;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_avs_waitrequest !== 1'h0 && n < 50);
    q = o_avs_readdata;
    i_avs_read <= 1'h0;
    i_avs_write <= 1'h0;
    if (n >= 50) chk("bus answer", 32'h0, 32'h1);
  endtask
  task automatic rst(input logic [12:0] w);
    @(posedge i_mclk);
    i_rst_b <= 1'h0;
    i_opt_word <= w;
    repeat (3) @(posedge i_mclk);
    i_rst_b <= 1'h1;
    tick(1);
  endtask
  task automatic count_irq(input logic lvl, output int n);
    n = 0;
    @(posedge i_mclk);
    i_cmp_out <= lvl;
    repeat (4) begin
      tick(1);
      if (o_cmp_irq === 1'h1) n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // full pass over one programmed option word
  task automatic run_opt(input logic [12:0] w);
    logic [31:0] q;
    int          nr, nf;
    rst(w);
    chk("bor level", w[3:1], o_brownout_reset_level);
    chk("boot fast", w[4], o_boot_fast);
    chk("wakeup", w[4] ? WF : WS, o_wakeup_cycles);
    chk("startup", w[4] ? SF : SS, o_startup_cycles);
    chk("tm2 bits", w[10] ? 7 : 6, o_tm2_pwm_bits);
    chk("led en rst", 0, o_led_pwm_fosc_en);
    chk("tm2 en rst", 0, o_tm2_fosc_en);
    chk("tm2 pwm rst", 0, o_tm2_pwm_en);
    for (int a = 4; a < 16; a += 4) begin
      bus(1'h0, 4'(a), 32'h0, q);
      chk("reg reset", 32'h0, q);
    end
    bus(1'h0, 4'h1, 32'h0, q);
    chk("unmapped", 32'h0, q);
    bus(1'h1, ccfg_pkg::REG_OPT_STAT, 32'h1fff ^ w, q);
    @(posedge i_mclk);
    i_opt_word <= ~w;
    bus(1'h0, ccfg_pkg::REG_OPT_STAT, 32'h0, q);
    chk("status", w, q);
    tick(2);
    chk("bor frozen", w[3:1], o_brownout_reset_level);
    bus(1'h1, ccfg_pkg::REG_LED_CLK, 32'h1, q);
    bus(1'h1, ccfg_pkg::REG_TM2_CTRL, 32'h20, q);
    bus(1'h1, ccfg_pkg::REG_TM2_SCALE, 32'h80, q);
    tick(2);
    chk("led en", 1, o_led_pwm_fosc_en);
    chk("led dbl", w[8], o_led_pwm_fosc_dbl);
    chk("tm2 en", 1, o_tm2_fosc_en);
    chk("tm2 dbl", w[9], o_tm2_fosc_dbl);
    chk("tm2 pwm", 1, o_tm2_pwm_en);
    bus(1'h1, ccfg_pkg::REG_TM2_CTRL, 32'h30, q);
    tick(2);
    chk("tm2 off", 0, o_tm2_fosc_en);
    // program read-back and irq pin routing in one cycle
    @(posedge i_mclk);
    i_prog_rd_req <= 1'h1;
    i_prog_rd_data <= 16'ha5c3;
    {i_pa0, i_pb5, i_pb0, i_pa4} <= 4'h9;
    tick(1);
    chk("rd valid", !w[0], o_prog_rd_valid);
    chk("rd refused", w[0], o_prog_rd_refused);
    chk("rd data", w[0] ? 0 : 16'ha5c3, o_prog_rd_data);
    chk("irq a", {w[6], !w[5]}, o_irq_src);
    i_prog_rd_req <= 1'h0;
    {i_pa0, i_pb5, i_pb0, i_pa4} <= 4'h6;
    i_pwm <= 8'h5a;
    tick(1);
    chk("irq b", {!w[6], w[5]}, o_irq_src);
    chk("pwm low cmp", w[7] ? 0 : 8'h5a, o_pwm);
    i_cmp_out <= 1'h1;
    tick(1);
    chk("pwm high cmp", 8'h5a, o_pwm);
    count_irq(1'h0, nf);
    count_irq(1'h1, nr);
    chk("fall irq", w[12:11] != 2'h1, nf);
    chk("rise irq", w[12:11] != 2'h2, nr);
    i_cmp_out <= 1'h0;
    $display("test done for option word %h", w);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: four words cover every edge code and both sides of each flag
  initial begin
    run_opt(13'h0000);
    run_opt(13'h0fff);
    run_opt(13'h1042);
    run_opt(13'h1885);
    end_of_test();
  end
endmodule
